/* hdl/drs_pkg.sv */
// Notes on behaviour
// [R1] low pulses on the reset pin under 5 us are ignored, over 9 us give a full reset.
// [R2] spikes inside a valid reset pulse are filtered too, so they do not break the reset; the code restarts its count on a spike before the reset is taken.
// [R3] each reset release reloads id bytes, common voltage and settings from nvm within 5 ms; the code reloads a sleep-out reset after its 120 ms blanking.
// [R4] a reset taken in sleep-in finishes its recovery within 5 ms of release.
// [R5] a reset taken in sleep-out may take up to 120 ms of recovery after release; the code recovers for 120 ms after its 120 ms blanking, up to 240 ms.
// [R6] the panel is blanked while resetting, with a blanking sequence of at most 120 ms from active.
// [R7] after the reset period all settings return to their hardware reset defaults.
// [R8] the host waits 5 ms after release before sending any command.
// [R9] the host sends no sleep-exit command until 120 ms after release.
// [R10] a ready flag stays low until recovery and reload are done; earlier commands are ignored.
package drs_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int REJECT_US        = 5;    // shorter pulses rejected
  localparam int ACCEPT_US        = 9;    // longer pulses always reset
  localparam int RECOVER_SLEEP_MS = 5;
  localparam int RECOVER_WAKE_MS  = 120;
  localparam int BLANK_MS         = 120;
  localparam int REJECT_CYC       = REJECT_US * CLK_MHZ;
  localparam int ACCEPT_CYC       = ACCEPT_US * CLK_MHZ;
  localparam int RECOVER_SLEEP_CYC = RECOVER_SLEEP_MS * 1000 * CLK_MHZ;
  localparam int RECOVER_WAKE_CYC  = RECOVER_WAKE_MS * 1000 * CLK_MHZ;
  localparam int BLANK_CYC         = BLANK_MS * 1000 * CLK_MHZ;
  // ----------------------------------------------------------------
  // nvm image and defaults
  // ----------------------------------------------------------------
  localparam int NVM_WORDS = 4;           // id1, id2, id3, common voltage
  localparam int NVM_IDX_COMV = 3;
  localparam logic [7:0] CMD_SLEEP_EXIT = 8'h11;
  localparam logic [7:0] CFG_RST_VAL    = 8'h00;
  typedef enum logic [2:0] {
    DRS_RUN    = 3'b000,
    DRS_RESET  = 3'b001,
    DRS_BLANK  = 3'b010,
    DRS_LOAD   = 3'b011,
    DRS_WAIT   = 3'b100
  } drs_state_t;
endpackage

/* hdl/drs_pin_filter.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// reset pin synchroniser and spike filter
// ------------------------------------------------------------------
module drs_pin_filter #(
  parameter int REJECT = 500,
  parameter int ACCEPT = 900
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // pin
  input  wire logic pin_n,
  // filtered level, high while reset is held
  output logic      rst_hold
);
  localparam int CW = $clog2(ACCEPT + 1);
  initial begin
    if (REJECT < 1 || ACCEPT <= REJECT) $error("bad filter thresholds");
  end
  logic [2:0]    sync_r;
  logic          stable_r;
  logic [CW-1:0] cnt_r;
  // three stage synchroniser
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) sync_r <= 3'h7;
    else         sync_r <= {sync_r[1:0], pin_n};
  end
  // agreed level once stages two and three match
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)                  stable_r <= 1'b1;
    else if (sync_r[1] == sync_r[2]) stable_r <= sync_r[2];
  end
  // level must differ from held state for REJECT cycles to flip it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_r    <= '0;
      rst_hold <= 1'b0;
    end else if (stable_r == rst_hold) begin // [R1] [R2]
      if (cnt_r == CW'(REJECT - 1)) begin
        cnt_r    <= '0;
        rst_hold <= ~rst_hold;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end else begin
      cnt_r <= '0;                           // spike: restart the count
    end
  end
  AST_SHORT_SPIKE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(rst_hold) |-> $past(stable_r, REJECT) == 1'b0) // [R1]
    else $error("reset taken after too short a pulse");
endmodule // drs_pin_filter

/* hdl/drs_seq.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// hardware reset sequencer
// ------------------------------------------------------------------
module drs_seq
  import drs_pkg::*;
#(
  parameter int RECOVER_SLEEP = drs_pkg::RECOVER_SLEEP_CYC,
  parameter int RECOVER_WAKE  = drs_pkg::RECOVER_WAKE_CYC,
  parameter int BLANK         = drs_pkg::BLANK_CYC
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // reset pin
  input  wire logic       hw_reset_n,
  // host command strobe
  input  wire logic       cmd_valid,
  input  wire logic [7:0] cmd_code,
  // nvm read port, one word per cycle
  output logic [1:0]      nvm_addr,
  input  wire logic [7:0] nvm_data,
  // status
  output logic            ready,
  output logic            panel_blank,
  output logic            sleep_out,
  output logic            cmd_accept,
  output logic [7:0]      common_voltage_setting,
  output logic [23:0]     id_bytes
);
  localparam int TW = 32;
  initial begin
    if (RECOVER_SLEEP < 1 || RECOVER_WAKE < RECOVER_SLEEP || BLANK < 1)
      $error("bad recovery counts");
  end
  drs_state_t     state_r;
  logic [TW-1:0]  tmr_r;
  logic [2:0]     ld_r;
  logic           rst_hold;
  logic           was_awake_r;
  logic           sleep_out_r;
  // ----------------------------------------------------------------
  // pin filter
  // ----------------------------------------------------------------
  drs_pin_filter #(.REJECT(REJECT_CYC), .ACCEPT(ACCEPT_CYC)) u_filt (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pin_n    (hw_reset_n),
    .rst_hold (rst_hold)
  );
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // blank if awake, reset, reload, then wait out the recovery window
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r     <= DRS_RESET;
      tmr_r       <= '0;
      ld_r        <= '0;
      was_awake_r <= 1'b0;
    end else if (rst_hold && state_r != DRS_RESET && state_r != DRS_BLANK) begin
      state_r     <= sleep_out_r ? DRS_BLANK : DRS_RESET; // [R6]
      was_awake_r <= sleep_out_r;
      tmr_r       <= '0;
    end else begin
      unique case (state_r)
        DRS_BLANK: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r == TW'(BLANK - 1)) begin
            state_r <= DRS_RESET;                            // [R6]
            tmr_r   <= '0;
          end
        end
        DRS_RESET: begin
          if (!rst_hold) begin
            state_r <= DRS_LOAD;                             // [R3]
            ld_r    <= '0;
            tmr_r   <= '0;
          end
        end
        // address and data registers put two cycles between a count and its word
        DRS_LOAD: begin
          tmr_r <= tmr_r + 1'b1;
          ld_r  <= ld_r + 1'b1;
          if (ld_r == 3'(NVM_WORDS + 1)) state_r <= DRS_WAIT; // [R3]
        end
        DRS_WAIT: begin
          tmr_r <= tmr_r + 1'b1;
          if (tmr_r >= TW'((was_awake_r ? RECOVER_WAKE : RECOVER_SLEEP) - 1))
            state_r <= DRS_RUN;                              // [R4] [R5]
        end
        DRS_RUN: tmr_r <= '0;
        default: state_r <= DRS_RESET;
      endcase
    end
  end
  // nvm address, data returns one cycle later
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) nvm_addr <= '0;
    else         nvm_addr <= ld_r[1:0];
  end
  // capture nvm words; defaults restored while resetting
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      id_bytes               <= '0;
      common_voltage_setting <= CFG_RST_VAL;
    end else if (state_r == DRS_RESET) begin
      id_bytes               <= '0;                          // [R7]
      common_voltage_setting <= CFG_RST_VAL;
    end else if (state_r == DRS_LOAD && ld_r >= 3'h2) begin
      // word k arrives while the count reads k + 2
      if (ld_r == 3'(NVM_IDX_COMV + 2)) common_voltage_setting <= nvm_data; // [R3]
      else id_bytes <= {id_bytes[15:0], nvm_data};
    end
  end
  // sleep mode: sleep-in after reset, woken by sleep-exit while running
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst)                  sleep_out_r <= 1'b0;
    else if (state_r != DRS_RUN)  sleep_out_r <= 1'b0;    // [R7]
    else if (cmd_valid && cmd_code == CMD_SLEEP_EXIT) sleep_out_r <= 1'b1;
  end
  // registered status outputs
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ready       <= 1'b0;
      panel_blank <= 1'b1;
      sleep_out   <= 1'b0;
      cmd_accept  <= 1'b0;
    end else begin
      ready       <= (state_r == DRS_RUN) && !rst_hold;     // [R10]
      panel_blank <= (state_r != DRS_RUN) || !sleep_out_r;  // [R6]
      sleep_out   <= sleep_out_r;
      cmd_accept  <= cmd_valid && state_r == DRS_RUN;       // [R10] [R8] [R9]
    end
  end
  AST_NO_CMD_EARLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_accept |-> $past(state_r) == DRS_RUN) // [R10]
    else $error("command accepted before ready");
  AST_BLANK_WHILE_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RESET) |=> panel_blank) // [R6]
    else $error("panel not blanked during reset");
  AST_DEFAULTS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RESET) |=> common_voltage_setting == CFG_RST_VAL && !sleep_out_r) // [R7]
    else $error("defaults not restored");
  AST_LOAD_SHORT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == DRS_LOAD) |-> ##[1:6] state_r == DRS_WAIT) // [R3]
    else $error("nvm reload too long");
  AST_NOT_READY_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_LOAD) |=> !ready) // [R10]
    else $error("ready during reload");
  AST_SLEEP_REC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_WAIT && !was_awake_r) |-> tmr_r < TW'(RECOVER_SLEEP + 8)) // [R4]
    else $error("sleep recovery overran");
  AST_WAKE_REC: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_WAIT) |-> tmr_r < TW'(RECOVER_WAKE + 8)) // [R5]
    else $error("wake recovery overran");
  AST_BLANK_MAX: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_BLANK) |-> tmr_r < TW'(BLANK)) // [R6]
    else $error("blanking overran");
  // ----------------------------------------------------------------
  // sequencing and status checks
  // ----------------------------------------------------------------
  // ready only follows a run cycle
  AST_READY_NEEDS_RUN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ready |-> $past(state_r) == DRS_RUN) // [R10]
    else $error("ready outside run");
  // ready drops as soon as a reset is held
  AST_READY_DROP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rst_hold |=> !ready) // [R10]
    else $error("ready while reset held");
  // ready stays low while resetting
  AST_READY_LOW_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RESET) |=> !ready) // [R10]
    else $error("ready during reset");
  // an accept needs a strobe one cycle earlier
  AST_ACCEPT_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_accept |-> $past(cmd_valid)) // [R10]
    else $error("accept without strobe");
  // no strobe, no accept
  AST_NO_ACCEPT_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cmd_valid |=> !cmd_accept) // [R10]
    else $error("accept while idle");
  // waking needs the sleep-exit code while running
  AST_WAKE_ONLY_RUN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(sleep_out_r) |-> $past(state_r) == DRS_RUN && $past(cmd_code) == CMD_SLEEP_EXIT)
    else $error("woken outside run"); // [R10]
  // a panel asleep stays blank
  AST_BLANK_ASLEEP: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !sleep_out_r |=> panel_blank) // [R6]
    else $error("panel lit while asleep");
  // a held reset leaves run at once
  AST_LEAVE_RUN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (rst_hold && state_r == DRS_RUN) |=> (state_r == DRS_RESET || state_r == DRS_BLANK))
    else $error("reset not taken from run"); // [R6]
  // blanking sequence only from the awake state
  AST_BLANK_ONLY_AWAKE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == DRS_BLANK) |-> was_awake_r) // [R6]
    else $error("blanking sequence while asleep");
  // release starts the reload next cycle
  AST_LOAD_AFTER_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RESET && !rst_hold) |=> state_r == DRS_LOAD) // [R3]
    else $error("reload not started");
  // waiting only follows a reload
  AST_WAIT_FROM_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == DRS_WAIT) |-> $past(state_r) == DRS_LOAD) // [R3]
    else $error("wait without reload");
  // run only follows the recovery wait
  AST_RUN_FROM_WAIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == DRS_RUN) |-> $past(state_r) == DRS_WAIT) // [R10]
    else $error("run without recovery");
  // id bytes back at default after reset
  AST_ID_DEFAULT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RESET) |=> id_bytes == '0) // [R7]
    else $error("id bytes not cleared");
  // reload starts asleep
  AST_ASLEEP_AFTER_RESET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state_r == DRS_LOAD) |-> !sleep_out_r) // [R7]
    else $error("awake after reset");
  // loaded common voltage holds while running
  AST_COMV_HELD_RUN: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (state_r == DRS_RUN && $past(state_r) == DRS_RUN) |-> $stable(common_voltage_setting))
    else $error("common voltage changed in run"); // [R3]
endmodule // drs_seq

/* bench/drs_host_model.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------------
// host pin driver and nvm model
// ------------------------------------------------------------------
module drs_host_model (
  // clock
  input  wire logic       clk_sys,
  // host side
  output logic            hw_reset_n,
  output logic            cmd_valid,
  output logic [7:0]      cmd_code,
  // nvm side
  input  wire logic [1:0] nvm_addr,
  output logic [7:0]      nvm_data
);
  logic [7:0] rom [4];
  // idle levels and nvm image, the bytes are arbitrary
  initial begin
    hw_reset_n = 1'b1;
    cmd_valid  = 1'b0;
    cmd_code   = 8'h00;
    nvm_data   = 8'h00;
    rom        = '{8'h5a, 8'h3c, 8'hc3, 8'h1e};
  end
  // synchronous read, word follows its address by one cycle
  always @(posedge clk_sys) nvm_data <= rom[nvm_addr];
  // pin low for a number of cycles, then released high
  task automatic pin_low(input int cyc);
    @(negedge clk_sys);
    hw_reset_n = 1'b0;
    repeat (cyc) @(negedge clk_sys);
    hw_reset_n = 1'b1;
  endtask
  // one-cycle strobe, code scrambled once released
  task automatic send(input logic [7:0] code);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_code  = ~code;
  endtask
endmodule // drs_host_model

/* bench/display_hw_reset_sequencer_bench.sv */
`timescale 1ns/10ps
module display_hw_reset_sequencer_bench;
  import drs_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hw_reset_n, cmd_valid, ready, panel_blank, sleep_out, cmd_accept;
  logic [7:0]  cmd_code, nvm_data, common_voltage_setting;
  logic [1:0]  nvm_addr;
  logic [23:0] id_bytes;
  logic        acc_seen = 1'b0;
  logic        rdy_low = 1'b0;
  logic        rdy_high = 1'b0;
  int          mismatches = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n;
  // ----------------------------------------------------------------
  // clock, instances, monitors
  // ----------------------------------------------------------------
  always #5 clk_sys = ~clk_sys;
  drs_seq #(.RECOVER_SLEEP(20), .RECOVER_WAKE(40), .BLANK(30)) u_drs_seq (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .nvm_addr(nvm_addr),
    .nvm_data(nvm_data), .ready(ready), .panel_blank(panel_blank),
    .sleep_out(sleep_out), .cmd_accept(cmd_accept),
    .common_voltage_setting(common_voltage_setting), .id_bytes(id_bytes));
  drs_host_model u_drs_host_model (
    .clk_sys(clk_sys), .hw_reset_n(hw_reset_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .nvm_addr(nvm_addr), .nvm_data(nvm_data));
  // sticky flags and the hang limit
  always @(posedge clk_sys) begin
    cycles++;
    if (cmd_accept === 1'b1) acc_seen <= 1'b1;
    if (ready !== 1'b1) rdy_low <= 1'b1;
    if (ready === 1'b1) rdy_high <= 1'b1;
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic wait_ready(input int lim);
    n = 0;
    while (ready !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n < lim, "ready late");
  endtask
  task automatic chk_image();
    logic [7:0] r [4];
    r = u_drs_host_model.rom;
    chk(id_bytes === {r[0], r[1], r[2]}, "id bytes");
    chk(common_voltage_setting === r[3], "common voltage");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up();
    u_drs_host_model.send(CMD_SLEEP_EXIT);
    repeat (3) @(negedge clk_sys);
    chk(acc_seen === 1'b0, "early command taken");
    wait_ready(700);
    chk_image();
    u_drs_host_model.send(CMD_SLEEP_EXIT);
    repeat (3) @(negedge clk_sys);
    chk(acc_seen === 1'b1 && sleep_out === 1'b1, "sleep exit lost");
  endtask
  task automatic t_spike();
    rdy_low = 1'b0;
    u_drs_host_model.pin_low(400);
    repeat (700) @(negedge clk_sys);
    chk(rdy_low === 1'b0, "spike reset");
  endtask
  task automatic t_wake_reset();
    u_drs_host_model.rom[0] = 8'ha5;
    u_drs_host_model.rom[3] = 8'h77;
    u_drs_host_model.pin_low(950);
    chk(ready === 1'b0 && panel_blank === 1'b1, "not blanked");
    wait_ready(2000);
    chk_image();
    chk(sleep_out === 1'b0, "state not default");
  endtask
  task automatic t_glitch();
    u_drs_host_model.pin_low(700);
    rdy_high = 1'b0;
    repeat (100) @(negedge clk_sys);
    u_drs_host_model.pin_low(400);
    chk(rdy_high === 1'b0, "glitch broke reset");
    wait_ready(1000);
  endtask
  task automatic tally_and_finish();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_power_up();
    t_spike();
    t_wake_reset();
    t_glitch();
    tally_and_finish();
  end
endmodule // display_hw_reset_sequencer_bench
